/* File: common/aor_ch_if.sv */
// per-channel signals between the restart control and one output channel
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface aor_ch_if;
  import aor_pkg::*;
  logic             force_zero;
  logic             tick;
  logic             conv_en;
  logic             in_use;
  aor_range_t       rng;
  logic [1:0]       hold;
  logic [15:0]      setv;
  logic [15:0]      code;
  logic             set_err;
  modport ctl (output force_zero, tick, conv_en, in_use, rng, hold, setv, input code, set_err);
  modport ch  (input force_zero, tick, conv_en, in_use, rng, hold, setv, output code, set_err);
endinterface

/* File: common/aor_pkg.sv */
// constants, types and register map of the analog output restart and gating block
// assumes a single 250 MHz clock domain and a plain word-addressed register port
package aor_pkg;

  // ==========================================================
  // widths
  localparam int NCH_DEF = 4;
  localparam int AW      = 8;
  localparam int DW      = 16;
  localparam int IRQ_W   = 3;

  // ==========================================================
  // register offsets (word index)
  localparam logic [7:0] A_CONV_EN     = 8'h00;
  localparam logic [7:0] A_SETVAL0     = 8'h01;
  localparam logic [7:0] A_SETUP_USE   = 8'h10;
  localparam logic [7:0] A_SETUP_RANGE = 8'h11;
  localparam logic [7:0] A_SETUP_HOLD  = 8'h12;
  localparam logic [7:0] A_ALARM       = 8'h18;
  localparam logic [7:0] A_IRQ_STAT    = 8'h19;
  localparam logic [7:0] A_IRQ_MASK    = 8'h1a;
  localparam logic [7:0] A_STATUS      = 8'h1b;
  localparam logic [7:0] A_RESTART_CNT = 8'h1c;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CONV_EN = 16'h0000;
  localparam logic [15:0] RST_SETVAL  = 16'h0000;
  localparam logic [15:0] RST_USE     = 16'h0000;
  localparam logic [15:0] RST_RANGE   = 16'h0000;
  localparam logic [15:0] RST_HOLD    = 16'h0000;
  localparam logic [15:0] RST_CODE    = 16'h0000;

  // ==========================================================
  // field positions
  localparam int ALM_SETUP_BIT = 10;
  localparam int ST_BUSY_BIT   = 0;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_SETVAL    = 1;
  localparam int IRQ_SETUP     = 2;

  // ==========================================================
  // signal ranges and their permitted set values
  typedef enum logic [1:0] {
    RNG_1_5V   = 2'h0,
    RNG_0_10V  = 2'h1,
    RNG_0_5V   = 2'h2,
    RNG_PM10V  = 2'h3
  } aor_range_t;

  localparam logic [15:0] UNI_LO = 16'hff38;
  localparam logic [15:0] UNI_HI = 16'h1068;
  localparam logic [15:0] BI_LO  = 16'hf7cc;
  localparam logic [15:0] BI_HI  = 16'h0834;

  // hold behaviour codes
  localparam logic [1:0] HOLD_CLR  = 2'h0;
  localparam logic [1:0] HOLD_LAST = 2'h1;
  localparam logic [1:0] HOLD_MAX  = 2'h2;

  // ==========================================================
  // timing
  localparam int T_RESTART_NS = 1000;
  localparam int CLK_NS       = 4;
  localparam int RESTART_CYC  = (T_RESTART_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_RESTART = 2'b01,
    ST_RUN     = 2'b10
  } aor_state_t;

endpackage

/* File: core/aor_channel.sv */
// one analog output channel: range check, hold behaviour and output code
// assumes tick is a one-cycle refresh pulse from the controlling module
`timescale 1ns/1ns
module aor_channel
  import aor_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  aor_ch_if.ch      port
);

  // ==========================================================
  // range check
  logic        in_range;
  logic [15:0] hold_code;

  always_comb begin
    if (port.rng == RNG_PM10V) begin
      in_range = ($signed(port.setv) >= $signed(BI_LO)) && ($signed(port.setv) <= $signed(BI_HI));
    end else begin
      in_range = ($signed(port.setv) >= $signed(UNI_LO)) && ($signed(port.setv) <= $signed(UNI_HI));
    end
  end

  // ==========================================================
  // hold value
  always_comb begin
    unique case (port.hold)
      HOLD_LAST: hold_code = port.code;
      HOLD_MAX:  hold_code = (port.rng == RNG_PM10V) ? BI_HI : UNI_HI;
      default:   hold_code = RST_CODE;
    endcase
  end

  // ==========================================================
  // output code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port.code <= RST_CODE;
    end else if (port.force_zero) begin
      port.code <= RST_CODE;
    end else if (port.tick && port.in_use) begin
      if (!port.conv_en || !in_range) begin
        port.code <= hold_code;
      end else begin
        port.code <= port.setv;
      end
    end
  end

  // live flag, drops by itself once the set value is back in range
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port.set_err <= 1'b0;
    end else begin
      port.set_err <= port.in_use && !in_range && !port.force_zero;
    end
  end

endmodule // aor_channel

/* File: core/aor_restart_gate.sv */
// restart sequencing and output gating of an analog output unit
// assumes io_refresh and restart_req are pins from the host controller
//
// Function
// - host pulses restart bit on then off; device restarts the unit.
// - during restart every output is forced to zero volts or milliamps.
// - power removal and reapply performs the same full restart.
// - setup memory changes apply only at restart; restart re-evaluates errors.
// - a channel not configured in use never updates its output.
// - conversion enable off applies hold; output follows set value once on.
// - out-of-range set value is not converted; output does not follow it.
// - out-of-range set value raises that channel's error flag, low alarm byte.
// - initial setting error flags stay until corrected and restarted.
`timescale 1ns/1ns
module aor_restart_gate
  import aor_pkg::*;
#(
  parameter int NCH            = NCH_DEF,
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 io_refresh,
  input  wire logic                 restart_req,
  input  wire logic [aor_pkg::AW-1:0] reg_addr,
  input  wire logic [aor_pkg::DW-1:0] reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [aor_pkg::DW-1:0] reg_rdata,
  output logic                      irq,
  output logic      [NCH*16-1:0]    dac_code,
  output logic                      dac_force_zero,
  output logic                      unit_busy
);

  import aor_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [2:0] req_sync;
  logic [2:0] ref_sync;
  logic       req_lvl;
  logic       ref_lvl;
  logic       ref_prev;
  logic       tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_sync <= 3'h0;
      ref_sync <= 3'h0;
    end else begin
      req_sync <= {req_sync[1:0], restart_req};
      ref_sync <= {ref_sync[1:0], io_refresh};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_lvl <= 1'b0;
      ref_lvl <= 1'b0;
    end else begin
      if (req_sync[2] == req_sync[1]) begin
        req_lvl <= req_sync[2];
      end
      if (ref_sync[2] == ref_sync[1]) begin
        ref_lvl <= ref_sync[2];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_lvl;
    end
  end

  assign tick = ref_lvl && !ref_prev;

  // ==========================================================
  // restart bit edge detection at refresh
  logic req_smp;
  logic armed;
  logic host_restart;

  // bit is only looked at on refresh, as the host updates it between refreshes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_smp <= 1'b0;
    end else if (tick) begin
      req_smp <= req_lvl;
    end
  end

  assign host_restart = tick && armed && req_smp && !req_lvl;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (tick && req_lvl && !req_smp) begin
      armed <= 1'b1;
    end else if (host_restart) begin
      armed <= 1'b0;
    end
  end

  // ==========================================================
  // restart sequencer
  aor_state_t  state;
  logic [15:0] cnt;
  logic        restarting;
  logic        restart_done;

  assign restarting   = (state == ST_RESTART);
  assign restart_done = restarting && (cnt == 16'(RESTART_CYCLES - 1));

  // reset lands in restart, so power-up runs the full sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_RESTART;
    end else begin
      unique case (state)
        ST_RESTART: if (restart_done) begin
          state <= ST_RUN;
        end
        ST_RUN: if (host_restart) begin
          state <= ST_RESTART;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
    end else if (!restarting) begin
      cnt <= 16'h0000;
    end else if (!restart_done) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ==========================================================
  // register file
  logic [15:0] conv_en;
  logic [15:0] setval [NCH];
  logic [15:0] setup_use;
  logic [15:0] setup_range;
  logic [15:0] setup_hold;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic [7:0]  restart_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_en <= RST_CONV_EN;
    end else if (reg_wr && reg_addr == A_CONV_EN) begin
      conv_en <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        setval[i] <= RST_SETVAL;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_wr && reg_addr == A_SETVAL0 + AW'(i)) begin
          setval[i] <= reg_wdata;
        end
      end
    end
  end

  // setup memory area: written any time, used only after restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_use   <= RST_USE;
      setup_range <= RST_RANGE;
      setup_hold  <= RST_HOLD;
    end else if (reg_wr) begin
      if (reg_addr == A_SETUP_USE) begin
        setup_use <= reg_wdata;
      end
      if (reg_addr == A_SETUP_RANGE) begin
        setup_range <= reg_wdata;
      end
      if (reg_addr == A_SETUP_HOLD) begin
        setup_hold <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= '0;
    end else if (reg_wr && reg_addr == A_IRQ_MASK) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      restart_cnt <= 8'h00;
    end else if (restart_done) begin
      restart_cnt <= restart_cnt + 8'h01;
    end
  end

  // ==========================================================
  // active setup copy
  logic [15:0] act_use;
  logic [15:0] act_range;
  logic [15:0] act_hold;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_use   <= RST_USE;
      act_range <= RST_RANGE;
      act_hold  <= RST_HOLD;
    end else if (restarting) begin
      act_use   <= setup_use;
      act_range <= setup_range;
      act_hold  <= setup_hold;
    end
  end

  // ==========================================================
  // initial setting error, judged on the copy at restart end
  logic bad_hold;
  logic setup_err;

  always_comb begin
    bad_hold = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (act_hold[2*i +: 2] > HOLD_MAX) begin
        bad_hold = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_err <= 1'b0;
    end else if (restart_done) begin
      setup_err <= bad_hold;
    end
  end

  // ==========================================================
  // channels
  logic [NCH-1:0] ch_err;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    aor_ch_if chif ();
    assign chif.force_zero = restarting;
    assign chif.tick       = tick && !setup_err;
    assign chif.conv_en    = conv_en[g];
    assign chif.in_use     = act_use[g];
    assign chif.rng        = aor_range_t'(act_range[2*g +: 2]);
    assign chif.hold       = act_hold[2*g +: 2];
    assign chif.setv       = setval[g];
    assign dac_code[16*g +: 16] = chif.code;
    assign ch_err[g]       = chif.set_err;
    aor_channel u_ch (
      .clk   (clk),
      .rst_b (rst_b),
      .port  (chif.ch)
    );
  end

  assign dac_force_zero = restarting;
  assign unit_busy      = restarting;

  // ==========================================================
  // interrupts
  logic [7:0]       alarm_lo;
  logic [7:0]       alarm_prev;
  logic [IRQ_W-1:0] irq_ev;
  logic             setup_err_prev;

  assign alarm_lo = 8'(ch_err);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_prev     <= 8'h00;
      setup_err_prev <= 1'b0;
    end else begin
      alarm_prev     <= alarm_lo;
      setup_err_prev <= setup_err;
    end
  end

  always_comb begin
    irq_ev             = '0;
    irq_ev[IRQ_DONE]   = restart_done;
    irq_ev[IRQ_SETVAL] = |(alarm_lo & ~alarm_prev);
    irq_ev[IRQ_SETUP]  = setup_err && !setup_err_prev;
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
    end else if (reg_wr && reg_addr == A_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // read port, data one cycle after the strobe
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == A_CONV_EN) begin
      rd_mux = conv_en;
    end else if (reg_addr == A_SETUP_USE) begin
      rd_mux = setup_use;
    end else if (reg_addr == A_SETUP_RANGE) begin
      rd_mux = setup_range;
    end else if (reg_addr == A_SETUP_HOLD) begin
      rd_mux = setup_hold;
    end else if (reg_addr == A_ALARM) begin
      rd_mux[7:0]           = alarm_lo;
      rd_mux[ALM_SETUP_BIT] = setup_err;
    end else if (reg_addr == A_IRQ_STAT) begin
      rd_mux[IRQ_W-1:0] = irq_stat;
    end else if (reg_addr == A_IRQ_MASK) begin
      rd_mux[IRQ_W-1:0] = irq_mask;
    end else if (reg_addr == A_STATUS) begin
      rd_mux[ST_BUSY_BIT] = restarting;
    end else if (reg_addr == A_RESTART_CNT) begin
      rd_mux[7:0] = restart_cnt;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_addr == A_SETVAL0 + AW'(i)) begin
          rd_mux = setval[i];
        end
      end
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // aor_restart_gate

/* File: test/analog_out_restart_gating_test.sv */
// self-checking bench for the restart and gating block
// assumes the host model drives refresh and restart pins; registers reached by strobes
`timescale 1ns/1ns
module analog_out_restart_gating_test;
  import aor_pkg::*;
  localparam int UNIT = 17;
  logic clk, rst_b, reg_wr, reg_rd, irq, dac_force_zero, unit_busy, io_refresh, restart_req;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [63:0] dac_code;
  logic [95:0] host_bits;
  int          fails, samples_checked;
  logic [15:0] sv [4] = '{16'h0fa0, 16'hf830, 16'h0100, 16'h0123};
  logic [15:0] ex [4] = '{16'h0fa0, 16'hf830, 16'h0100, 16'h0000};

  aor_restart_gate #(.NCH(4), .RESTART_CYCLES(8)) DUT (.clk(clk), .rst_b(rst_b), .io_refresh(io_refresh),
    .restart_req(restart_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .dac_code(dac_code), .dac_force_zero(dac_force_zero),
    .unit_busy(unit_busy));
  aor_host_model #(.UNIT(UNIT)) host (.clk(clk), .rst_b(rst_b), .host_bits(host_bits),
    .io_refresh(io_refresh), .restart_req(restart_req));

  // ====================
  // tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp, "read");
  endtask

  task automatic code_is(input int g, input logic [15:0] e);
    cmp(dac_code[g*16 +: 16], e, "code");
  endtask

  // codes land a few clocks after the synchronised refresh edge
  task automatic ticks(input int n);
    repeat (n) @(posedge io_refresh);
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (unit_busy !== lvl && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({15'h0000, unit_busy}, {15'h0000, lvl}, "busy");
  endtask

  task automatic do_restart();
    @(posedge clk);
    host_bits[UNIT] <= 1'b1;
    ticks(2);
    @(posedge clk);
    host_bits[UNIT] <= 1'b0;
    wait_busy(1'b1);
    @(posedge clk);
    #1;
    for (int g = 0; g < 4; g++) code_is(g, 16'h0000);
    rd(A_STATUS, 16'h0001);
    wait_busy(1'b0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end

  // ====================
  // tests
  initial begin
    rst_b = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0; host_bits = '0;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wait_busy(1'b0);
    rd(A_IRQ_STAT, 16'h0001);
    rd(A_SETUP_USE, RST_USE);
    wr(8'h30, 16'hffff);
    rd(8'h30, 16'h0000);
    $display("done: reset");
    wr(A_IRQ_STAT, 16'h0007);
    wr(A_IRQ_MASK, 16'h0001);
    wr(A_SETUP_USE, 16'h0007);
    wr(A_SETUP_RANGE, 16'h000d);
    wr(A_SETUP_HOLD, 16'h0009);
    for (int g = 0; g < 4; g++) wr(A_SETVAL0 + 8'(g), sv[g]);
    wr(A_CONV_EN, 16'h000f);
    ticks(2);
    for (int g = 0; g < 4; g++) code_is(g, 16'h0000);
    cmp({15'h0000, irq}, 16'h0000, "irq idle");
    do_restart();
    cmp({15'h0000, irq}, 16'h0001, "irq done");
    wr(A_IRQ_MASK, 16'h0000);
    cmp({15'h0000, irq}, 16'h0000, "irq masked");
    wr(A_IRQ_MASK, 16'h0001);
    wr(A_IRQ_STAT, 16'h0001);
    cmp({15'h0000, irq}, 16'h0000, "irq cleared");
    ticks(2);
    for (int g = 0; g < 4; g++) code_is(g, ex[g]);
    $display("done: restart");
    wr(A_SETVAL0, 16'h0200);
    wr(A_CONV_EN, 16'h000e);
    ticks(2);
    code_is(0, 16'h0fa0);
    wr(A_CONV_EN, 16'h000f);
    ticks(2);
    code_is(0, 16'h0200);
    wr(A_SETVAL0 + 8'h01, 16'h0835);
    wr(A_SETVAL0 + 8'h02, 16'h1069);
    ticks(2);
    code_is(1, BI_HI);
    code_is(2, 16'h0000);
    rd(A_ALARM, 16'h0006);
    rd(A_IRQ_STAT, 16'h0002);
    wr(A_SETVAL0 + 8'h01, BI_LO);
    wr(A_SETVAL0 + 8'h02, UNI_LO);
    ticks(2);
    code_is(1, BI_LO);
    code_is(2, UNI_LO);
    rd(A_ALARM, 16'h0000);
    $display("done: hold and range");
    wr(A_SETUP_HOLD, 16'h0003);
    do_restart();
    rd(A_ALARM, 16'h0400);
    rd(A_IRQ_STAT, 16'h0007);
    wr(A_SETVAL0 + 8'h02, 16'h0010);
    wr(A_SETUP_HOLD, 16'h0009);
    ticks(2);
    code_is(2, 16'h0000);
    rd(A_ALARM, 16'h0400);
    do_restart();
    rd(A_ALARM, 16'h0000);
    ticks(2);
    code_is(2, 16'h0010);
    rd(A_RESTART_CNT, 16'h0004);
    $display("done: setting error");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    code_is(0, 16'h0000);
    cmp({15'h0000, dac_force_zero}, 16'h0001, "zero in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    wait_busy(1'b0);
    rd(A_SETUP_USE, 16'h0000);
    rd(A_RESTART_CNT, 16'h0001);
    rd(A_STATUS, 16'h0000);
    ticks(2);
    code_is(1, 16'h0000);
    $display("done: power cycle");
    wrap_up();
  end
endmodule // analog_out_restart_gating_test

/* File: test/aor_host_model.sv */
// host controller model: i/o refresh strobe and the packed restart bit word
// assumes the bench writes host_bits; the word reaches the pin only between refreshes
`timescale 1ns/1ns
module aor_host_model #(
  parameter int UNIT   = 5,
  parameter int PERIOD = 24
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [95:0] host_bits,
  output logic             io_refresh,
  output logic             restart_req
);
  // ====================
  // refresh strobe and restart word
  int unsigned phase;
  logic [95:0] bit_word;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase      <= 0;
      io_refresh <= 1'b0;
    end else begin
      phase      <= (phase == PERIOD - 1) ? 0 : phase + 1;
      io_refresh <= (phase < PERIOD / 4);
    end
  end

  // copied mid-gap so the level is steady across every refresh
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_word <= '0;
    end else if (phase == PERIOD / 2) begin
      bit_word <= host_bits;
    end
  end

  assign restart_req = bit_word[UNIT];
endmodule // aor_host_model

/* File: test/aor_restart_gate_props.sv */
// port-level assertions for the restart and gating block
// assumes one clock domain; bound to every instance of the top module
`timescale 1ns/1ns
module aor_restart_gate_chk
  import aor_pkg::*;
#(
  parameter int NCH            = NCH_DEF,
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   restart_req,
  input wire logic [aor_pkg::AW-1:0] reg_addr,
  input wire logic [aor_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [aor_pkg::DW-1:0] reg_rdata,
  input wire logic                   irq,
  input wire logic [NCH*16-1:0]      dac_code,
  input wire logic                   dac_force_zero,
  input wire logic                   unit_busy
);
  // ====================
  // helper logic
  int unsigned run_len;
  logic        seen_low;

  // power-up run length is not exact, so only runs after an idle spell count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_len <= 0;
    end else begin
      run_len <= unit_busy ? run_len + 1 : 0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_low <= 1'b0;
    end else if (!unit_busy) begin
      seen_low <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ====================
  // assertions
  busy_match_a: assert property (unit_busy == dac_force_zero)
    else $error("busy and force zero differ");
  zero_out_a: assert property (dac_force_zero [*2] |-> dac_code == '0)
    else $error("output code not zero during restart");
  restart_len_a: assert property ($fell(unit_busy) && seen_low |-> run_len == RESTART_CYCLES)
    else $error("restart length wrong");
  restart_low_a: assert property ($rose(unit_busy) |-> !restart_req && !$past(restart_req, 3))
    else $error("restart began while request bit high");
  powerup_state_a: assert property ($rose(rst_b) |-> unit_busy && dac_code == '0)
    else $error("not restarting after power-up");
  status_busy_a: assert property (reg_rd && reg_addr == A_STATUS |=> reg_rdata[ST_BUSY_BIT] == $past(unit_busy))
    else $error("status busy bit wrong");
  alarm_field_a: assert property (reg_rd && reg_addr == A_ALARM |=> reg_rdata[15:11] == '0 && reg_rdata[9:NCH] == '0)
    else $error("alarm bits outside channel field");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  mask_off_a: assert property (reg_wr && reg_addr == A_IRQ_MASK && reg_wdata == '0 |=> !irq)
    else $error("irq high with mask cleared");

  cover property ($rose(unit_busy));
  cover property ($rose(irq));
  cover property (reg_rd && reg_addr == A_ALARM ##1 reg_rdata != '0);
endmodule // aor_restart_gate_chk

bind aor_restart_gate aor_restart_gate_chk #(.NCH(NCH), .RESTART_CYCLES(RESTART_CYCLES)) chk (
  .clk(clk), .rst_b(rst_b), .restart_req(restart_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dac_code(dac_code),
  .dac_force_zero(dac_force_zero), .unit_busy(unit_busy));
